// >>> design/pin_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st.stage1 = pins;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= {RESET_VALUE, RESET_VALUE};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign synced = st.stage2;

endmodule : pin_sync
`default_nettype wire

// >>> design/result_fifo.sv
// Small synchronous FIFO carrying conversion results.
// Assumes writer and reader share the clock and clock enable.
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] head;
    logic head_valid;
  } fifo_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_t st;
  fifo_state_t next_st;
  logic do_wr;
  logic do_rd;

  assign in_ready = (st.count < (AW+1)'(DEPTH));
  assign do_wr = in_valid && in_ready;
  assign out_valid = st.head_valid;
  assign out_data = st.head;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The head register is refilled from memory whenever it empties, so the
  // read data always come out of a flip-flop.
  always_comb begin
    next_st = st;
    do_rd = 1'b0;
    if (do_wr) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (st.head_valid && out_ready) begin
      next_st.head_valid = 1'b0;
    end
    if ((!st.head_valid || out_ready) && st.count != '0) begin
      do_rd = 1'b1;
      next_st.head = mem[st.rd_ptr];
      next_st.head_valid = 1'b1;
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && do_wr) begin
      mem[st.wr_ptr] <= in_data;
    end
  end

endmodule : result_fifo
`default_nettype wire

// >>> design/sar_adc_ctrl.sv
// Conversion control and parallel result port of a successive-approximation converter.
// Assumes the analog core supplies a finished raw code, taken at the end of conversion,
// and that the host's strobes and selects arrive asynchronously on pins.
//
// How it works
// - A started conversion always completes; new strobes and power-down are ignored.
// - Convert strobe is watched regardless of chip select and read strobe.
// - Falling strobe edge starts a conversion; busy stays high until done.
// - Strobe still low when busy falls: acquisition is timed internally, then conversion.
// - Strobe held low keeps acquisition and conversion cycling on its own.
// - Self-running rate may slightly exceed nominal throughput; host must cope. Here one idle cycle per loop keeps it just below.
// - Core power is lowered when each conversion ends, through acquisition.
// - The read port keeps working while the core sleeps.
// - Coding select picks twos complement or straight binary output.
// - Data pins are driven only while chip select and read are both low.
// - Read strobe places the result on the bus; chip select picks the device.
// - Serial output would share the parallel data pins.
// - Port style select low means parallel bus operation.
// - Result readable after conversion, in acquisition, or during the next one.
// - Bit decisions end, code is produced, then busy falls.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_ctrl
  import sar_ctrl_pkg::*;
#(
  parameter int unsigned WIDTH = RESULT_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned CONV_CYCLES = CONVERT_CYCLES,
  parameter int unsigned ACQ_WAIT_CYCLES = ACQ_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic convert_start_n,
  input wire logic power_down_input,
  input wire logic output_coding_select,
  input wire logic port_style_select,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic [WIDTH-1:0] core_raw_code,
  output logic busy,
  output logic core_power_up,
  output logic sample_hold,
  output logic [WIDTH-1:0] data_out,
  output logic [WIDTH-1:0] data_oe,
  output logic result_valid,
  input wire logic result_ready,
  output logic [WIDTH-1:0] result_data,
  output logic fifo_overflow
);

  localparam int unsigned CW = $clog2((CONV_CYCLES > ACQ_WAIT_CYCLES ?
                                       CONV_CYCLES : ACQ_WAIT_CYCLES) + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Both strobes reset high so that release from reset is not a falling edge.
  logic [5:0] pins_sync;

  pin_sync #(
    .WIDTH(6),
    .RESET_VALUE(6'h23)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .pins({convert_start_n, power_down_input, output_coding_select,
           port_style_select, chip_select_n, read_n}),
    .synced(pins_sync)
  );

  logic cnv_n_s;
  logic pd_s;
  logic coding_s;
  logic style_s;
  logic cs_n_s;
  logic rd_n_s;

  assign {cnv_n_s, pd_s, coding_s, style_s, cs_n_s, rd_n_s} = pins_sync;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    conv_state_t state;
    logic cnv_prev;
    logic [CW-1:0] count;
    logic [WIDTH-1:0] result;
    logic [WIDTH-1:0] data_out;
    logic drive;
    logic push;
    logic overflow;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic fifo_in_ready;
  logic [WIDTH-1:0] coded;
  logic bus_read;

  // Chip select and read gate only the data pins, never the strobe path.
  assign bus_read = !cs_n_s && !rd_n_s && !style_s;
  assign coded = apply_coding(core_raw_code, coding_s);

  always_comb begin
    next_st = st;
    next_st.cnv_prev = cnv_n_s;
    next_st.push = 1'b0;
    case (st.state)
      ST_IDLE: begin
        // Power-down holds the converter off between conversions only.
        if (!pd_s && st.cnv_prev && !cnv_n_s) begin
          next_st.state = ST_CONVERT;
          next_st.count = '0;
        end else if (!pd_s && !cnv_n_s) begin
          next_st.state = ST_ACQUIRE;
          next_st.count = '0;
        end
      end
      ST_CONVERT: begin
        // Strobe and power-down are not looked at here.
        if (st.count == CW'(CONV_CYCLES - 1)) begin
          next_st.result = coded;
          next_st.push = 1'b1;
          next_st.state = ST_IDLE;
          next_st.count = '0;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
      ST_ACQUIRE: begin
        // Internally timed acquisition for self-running mode.
        if (cnv_n_s || pd_s) begin
          next_st.state = ST_IDLE;
        end else if (st.count == CW'(ACQ_WAIT_CYCLES - 1)) begin
          next_st.state = ST_CONVERT;
          next_st.count = '0;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
    // The previous result stays on the bus throughout the next conversion.
    next_st.drive = bus_read;
    next_st.data_out = next_st.result;
    // The overflow flag is sticky: a result lost to a full FIFO is reported.
    if (st.push && !fifo_in_ready) begin
      next_st.overflow = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{state: ST_IDLE, cnv_prev: 1'b1, count: '0, result: RESULT_RESET,
              data_out: RESULT_RESET, drive: 1'b0, push: 1'b0, overflow: 1'b0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign busy = (st.state == ST_CONVERT);
  assign core_power_up = (st.state == ST_CONVERT);
  assign sample_hold = (st.state == ST_CONVERT);
  assign data_out = st.data_out;
  assign data_oe = {WIDTH{st.drive}};
  assign fifo_overflow = st.overflow;

  // ----------------------------------------------------------------
  // Result stream
  // ----------------------------------------------------------------
  // Each finished result is also offered on a stream; a stalled reader
  // fills the FIFO and further results are dropped and flagged.
  result_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_result_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .in_valid(st.push),
    .in_ready(fifo_in_ready),
    .in_data(st.result),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

endmodule : sar_adc_ctrl
`default_nettype wire

// >>> design/sar_ctrl_pkg.sv
// Shared constants for the converter control block.
// Assumes a single 200 MHz core clock.
package sar_ctrl_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_WIDTH = 16;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Conversion phase length, nanoseconds.
  localparam int unsigned CONVERT_TIME_NS = 1250;
  localparam int unsigned CONVERT_CYCLES = (CONVERT_TIME_NS * 1000) / CLK_PERIOD_PS;
  // Acquisition time timed internally in self-running mode, nanoseconds.
  localparam int unsigned ACQ_TIME_NS = 750;
  localparam int unsigned ACQ_CYCLES = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Reset value and coding mask
  // ----------------------------------------------------------------
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 16'h0000;
  localparam logic [RESULT_WIDTH-1:0] SIGN_FLIP = 16'h8000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_ACQUIRE
  } conv_state_t;

  // Straight binary when the coding select is high, twos complement when low.
  function automatic logic [RESULT_WIDTH-1:0] apply_coding(
    input logic [RESULT_WIDTH-1:0] raw,
    input logic straight_binary
  );
    apply_coding = straight_binary ? raw : (raw ^ SIGN_FLIP);
  endfunction : apply_coding

endpackage : sar_ctrl_pkg

// >>> testbench/host_reader.sv
// Host model: parallel reads by chip select and read strobe, stream pops.
// Assumes the bench calls read_word from its main sequence.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input wire logic core_clk,
  input wire logic stall,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  output logic chip_select_n,
  output logic read_n,
  output logic result_ready
);
  logic [15:0] got[$];
  int seed = 32'hf0cc;
  initial begin
    chip_select_n = 1'b1;
    read_n = 1'b1;
    result_ready = 1'b0;
  end
  // Random ready gives the stream both prompt and slow pops.
  always @(posedge core_clk) begin
    if (result_valid && result_ready) got.push_back(result_data);
    result_ready <= !stall && (($random(seed) & 1) != 0);
  end
  task automatic read_word(output logic [15:0] v, output logic [15:0] oe);
    int n;
    // A bus still driven from the previous access would be taken as the answer.
    for (n = 0; n < 8 && data_oe !== 16'h0000; n++) @(negedge core_clk);
    @(posedge core_clk);
    chip_select_n <= 1'b0;
    read_n <= 1'b0;
    for (n = 0; n < 8 && data_oe !== 16'hffff; n++) @(negedge core_clk);
    v = data_out;
    oe = data_oe;
    @(posedge core_clk);
    chip_select_n <= 1'b1;
    read_n <= 1'b1;
  endtask : read_word
endmodule : host_reader
`default_nettype wire

// >>> testbench/sar_adc_ctrl_checker.sv
// Port assertions for the converter control block.
// Assumes clk_en is held high, so every clock edge advances the block.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_ctrl_checker #(
  parameter int unsigned CONV_CYCLES = 16,
  parameter int unsigned ACQ_WAIT_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic convert_start_n,
  input wire logic power_down_input,
  input wire logic port_style_select,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic busy,
  input wire logic core_power_up,
  input wire logic sample_hold,
  input wire logic [15:0] data_oe,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic [15:0] result_data,
  input wire logic fifo_overflow
);
  localparam int ACQ_HI = ACQ_WAIT_CYCLES + 8;
  int busy_len;
  logic off;
  assign off = chip_select_n | read_n | port_style_select;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) busy_len <= 0;
    else busy_len <= busy ? busy_len + 1 : 0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  power_follow_a: assert property (core_power_up == busy)
    else $error("core power differs from busy");
  hold_follow_a: assert property (sample_hold == busy)
    else $error("sample hold differs from busy");
  busy_length_a: assert property ($fell(busy) |-> busy_len == int'(CONV_CYCLES))
    else $error("conversion length wrong");
  start_busy_a: assert property ($fell(convert_start_n) && !busy && !power_down_input
    && !$past(power_down_input, 3) |-> ##[1:5] busy) else $error("strobe did not start");
  self_run_a: assert property ($fell(busy) && !convert_start_n && !power_down_input
    |-> !busy[*3] ##[1:ACQ_HI] busy) else $error("self run did not restart");
  oe_off_a: assert property (off[*5] |-> data_oe == 16'h0000)
    else $error("bus driven while deselected");
  // A read holds its strobes for four samples: two synchroniser stages and the output flop.
  oe_on_a: assert property ((!off)[*4] |-> data_oe == 16'hffff)
    else $error("bus not driven while read");
  stream_hold_a: assert property (result_valid && !result_ready |=>
    result_valid && $stable(result_data)) else $error("stream word not held");
  overflow_keep_a: assert property (fifo_overflow |=> fifo_overflow)
    else $error("overflow flag dropped");
  cover property ($fell(busy) && !convert_start_n);
  cover property (data_oe == 16'hffff && busy);
  cover property ($rose(fifo_overflow));
endmodule : sar_adc_ctrl_checker
`default_nettype wire

// >>> testbench/test_sar_adc_convert_and_parallel_read.sv
// Self-checking bench for the converter control block.
// Assumes the design, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_convert_and_parallel_read;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cnv_n = 1'b1;
  logic pd = 1'b0;
  logic obsel = 1'b1;
  logic pss = 1'b0;
  logic stall = 1'b0;
  logic [15:0] raw = 16'h0000;
  logic [15:0] v, oe, prev, dout, doe, rdata;
  logic busy, cs_n, rd_n, rdy, valid, ovf;
  logic [15:0] exp_q[$];
  int seed = 32'hf0cc;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  sar_adc_ctrl #(.CONV_CYCLES(16), .ACQ_WAIT_CYCLES(4)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .clk_en(1'b1), .convert_start_n(cnv_n),
    .power_down_input(pd), .output_coding_select(obsel), .port_style_select(pss),
    .chip_select_n(cs_n), .read_n(rd_n), .core_raw_code(raw), .busy(busy),
    .core_power_up(), .sample_hold(), .data_out(dout), .data_oe(doe),
    .result_valid(valid), .result_ready(rdy), .result_data(rdata), .fifo_overflow(ovf));
  host_reader u_host (
    .core_clk(core_clk), .stall(stall), .data_out(dout), .data_oe(doe),
    .result_valid(valid), .result_data(rdata), .chip_select_n(cs_n), .read_n(rd_n),
    .result_ready(rdy));
  task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : check
  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  function automatic logic [15:0] coded(input logic [15:0] r, input logic sb);
    return sb ? r : {~r[15], r[14:0]};
  endfunction : coded
  task automatic wait_busy(input logic lvl);
    int n = 0;
    do @(negedge core_clk); while (busy !== lvl && ++n < 400);
    check("busy", 16'(lvl), 16'(busy));
  endtask : wait_busy
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      $display("Error cycles expected %0d seen %0d", 5999, cyc);
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      obsel <= i[0];
      raw <= (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
      repeat (4) @(posedge core_clk);
      cnv_n <= 1'b0;
      wait_busy(1'b1);
      @(posedge core_clk) cnv_n <= 1'b1;
      if (i == 6) begin
        u_host.read_word(v, oe);
        check("data_out", prev, v);
      end
      wait_busy(1'b0);
      u_host.read_word(v, oe);
      check("data_out", coded(raw, obsel), v);
      check("data_oe", 16'hffff, oe);
      prev = v;
    end
    @(posedge core_clk) pss <= 1'b1;
    u_host.read_word(v, oe);
    check("data_oe", 16'h0000, oe);
    @(posedge core_clk) pss <= 1'b0;
    cnv_n <= 1'b0;
    wait_busy(1'b1);
    @(posedge core_clk) cnv_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    cnv_n <= 1'b0;
    pd <= 1'b1;
    wait_busy(1'b0);
    repeat (12) @(negedge core_clk);
    check("busy", 16'h0000, 16'(busy));
    @(posedge core_clk) cnv_n <= 1'b1;
    pd <= 1'b0;
    repeat (20) @(posedge core_clk);
    u_host.got.delete();
    stall <= 1'b1;
    repeat (4) @(posedge core_clk);
    cnv_n <= 1'b0;
    for (int k = 0; k < 18; k++) begin
      wait_busy(1'b1);
      if (k == 17) @(posedge core_clk) cnv_n <= 1'b1;
      wait_busy(1'b0);
      exp_q.push_back(coded(raw, obsel));
      @(posedge core_clk) raw <= 16'($random(seed));
    end
    repeat (4) @(negedge core_clk);
    check("overflow", 16'h0001, 16'(ovf));
    @(posedge core_clk) stall <= 1'b0;
    repeat (100) @(posedge core_clk);
    check("count", 16'h0011, 16'(u_host.got.size()));
    for (int k = 0; k < 17; k++) check("result", exp_q[k], u_host.got[k]);
    summarize();
  end
endmodule : test_sar_adc_convert_and_parallel_read
bind sar_adc_ctrl sar_adc_ctrl_checker #(.CONV_CYCLES(CONV_CYCLES),
  .ACQ_WAIT_CYCLES(ACQ_WAIT_CYCLES)) u_chk (.core_clk(core_clk), .rstn(rstn),
  .convert_start_n(convert_start_n), .power_down_input(power_down_input),
  .port_style_select(port_style_select), .chip_select_n(chip_select_n), .read_n(read_n),
  .busy(busy), .core_power_up(core_power_up), .sample_hold(sample_hold), .data_oe(data_oe),
  .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
  .fifo_overflow(fifo_overflow));
`default_nettype wire
